// ==== rtl/srtc_top.sv ====
// Clock-calendar SRAM: bus decode, storage, time counters and calibration.
`timescale 1ns/1ns
`default_nettype none
module srtc_top (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // Memory bus pins
    input  wire logic                        chip_select_n,
    input  wire logic                        output_enable_n,
    input  wire logic                        write_strobe_n,
    input  wire logic [srtc_pkg::ADDR_W-1:0] address_lines,
    input  wire logic [srtc_pkg::DATA_W-1:0] data_lines_in,
    output var  logic [srtc_pkg::DATA_W-1:0] data_lines_out,
    output var  logic                        data_lines_oe,
    // Supply monitor and oscillator
    input  wire logic                        power_fail,
    input  wire logic                        battery_low_sense,
    input  wire logic                        osc_clk,
    // Status
    output var  logic                        battery_low_flag
);

    srtc_pkg::srtc_pins_s  pins_raw;
    srtc_pkg::srtc_pins_s  pins;
    srtc_pkg::srtc_state_s s;
    srtc_pkg::srtc_state_s next_s;

    logic                        mem_we;
    logic [srtc_pkg::DATA_W-1:0] mem_rdata;

    // Combinational working values.
    logic                        osc_rise;
    logic                        bus_ok;
    logic                        wr_now;
    logic                        adj_on;
    logic [8:0]                  sub_term;
    logic [8:0]                  sub_inc;
    logic                        sec_tick;
    logic                        hold;
    logic [8:0]                  r;
    logic                        carry;
    srtc_pkg::srtc_time_s        c;
    logic [7:0]                  rd_clk;
    logic [7:0]                  new_ctrl;

    assign pins_raw = '{
        chip_select_n:     chip_select_n,
        output_enable_n:   output_enable_n,
        write_strobe_n:    write_strobe_n,
        address_lines:     address_lines,
        data_lines:        data_lines_in,
        power_fail:        power_fail,
        battery_low_sense: battery_low_sense,
        osc_clk:           osc_clk
    };

    // Address and data share the strobes' two stages; the host holds them
    // steady around the strobes, so the last overlapped sample is whole.
    srtc_sync #(
        .WIDTH ($bits(srtc_pkg::srtc_pins_s))
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .d       (pins_raw),
        .q       (pins)
    );

    srtc_mem u_mem (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wr_en   (mem_we),
        .wr_addr (s.wr_addr),
        .wr_data (s.wr_data),
        .rd_addr (pins.address_lines),
        .rd_data (mem_rdata)
    );

    // BCD increment with wrap: returns the carry on top of the new value.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [8:0] res;
        if (v >= hi) begin
            res = {1'b1, lo};
        end else if (v[3:0] == srtc_pkg::BCD_NINE) begin
            res = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            res = {1'b0, 8'(v + 8'h01)};
        end
        return res;
    endfunction

    // Last date of a month; a year is taken as leap when divisible by four.
    function automatic logic [7:0] month_last(input logic [7:0] month,
                                              input logic [7:0] year);
        logic       leap;
        logic [7:0] res;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        unique case (month)
            8'h02:                      res = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: res = 8'h30;
            default:                    res = 8'h31;
        endcase
        return res;
    endfunction

    // Address decode used on both the read and the write path.
    function automatic logic in_clock_page(input logic [srtc_pkg::ADDR_W-1:0] a);
        return a[srtc_pkg::ADDR_W-1:3] == srtc_pkg::CLK_PAGE;
    endfunction

    // Calibration magnitude, read by the enable and by the minute window.
    function automatic logic [4:0] cal_mag(input logic [7:0] ctrl);
        return ctrl[srtc_pkg::CAL_MSB:0];
    endfunction

    always_comb begin
        next_s   = s;
        mem_we   = 1'b0;
        osc_rise = pins.osc_clk & ~s.osc_prev;
        next_s.osc_prev = pins.osc_clk;
        hold     = s.clock_control[srtc_pkg::CTRL_READ_BIT]
                 | s.clock_control[srtc_pkg::CTRL_WRITE_BIT];
        c        = s.cnt;
        r        = '0;
        carry    = 1'b0;
        new_ctrl = s.wr_data;
        sec_tick = 1'b0;
        sub_inc  = 9'(s.sub + 9'h001);

        // Capture a possible low battery once the synchroniser has settled.
        // The sync stages reset low, so the strobes look active for two clocks;
        // the bus stays dead until this wait is over.
        if (!s.init_done) begin
            next_s.init_cnt = 2'(s.init_cnt + 2'h1);
            if (s.init_cnt == srtc_pkg::INIT_WAIT) begin
                next_s.init_done        = 1'b1;
                next_s.battery_low_flag = pins.battery_low_sense;
            end
        end

        // A power failure makes every bus input a don't-care.
        bus_ok = s.init_done & ~pins.power_fail;

        // Write is live only during the overlap of both strobes.
        // Whichever strobe falls last opens it and whichever rises first ends it.
        wr_now = bus_ok & ~pins.chip_select_n & ~pins.write_strobe_n;
        next_s.wr_act = wr_now;
        if (wr_now) begin
            // Keep the last sampled address and data; the host holds them steady.
            next_s.wr_addr = pins.address_lines;
            next_s.wr_data = pins.data_lines;
        end

        // Calibration: one second per minute in the first 2N minutes.
        // The minute counters run free of the BCD time, so loading the clock
        // does not move the 64-minute calibration window.
        adj_on = (cal_mag(s.clock_control) != srtc_pkg::CAL_ZERO)
               && (s.sec_in_min == 6'h00)
               && (s.cal_min < {cal_mag(s.clock_control), 1'b0});
        if (!adj_on) begin
            sub_term = srtc_pkg::SUB_TERM_NOM;
        end else if (s.clock_control[srtc_pkg::CTRL_SIGN_BIT]) begin
            sub_term = srtc_pkg::SUB_TERM_FAST;
        end else begin
            sub_term = srtc_pkg::SUB_TERM_SLOW;
        end

        // Divider chain runs only while the stop bit is clear.
        // A second lasts sub_term steps of 128 oscillator edges; a stop keeps
        // the prescaler where it was, so a restart resumes the same step.
        if (osc_rise && !s.vis.sec[srtc_pkg::SEC_HALT_BIT]) begin
            next_s.pre = 7'(s.pre + 7'h01);
            if (s.pre == srtc_pkg::PRE_LAST) begin
                next_s.pre = '0;
                if (sub_inc >= sub_term) begin
                    next_s.sub = '0;
                    sec_tick   = 1'b1;
                end else begin
                    next_s.sub = sub_inc;
                end
            end
        end

        if (sec_tick) begin
            if (s.sec_in_min == srtc_pkg::SEC_PER_MIN_LAST) begin
                next_s.sec_in_min = '0;
                next_s.cal_min    = 6'(s.cal_min + 6'h01);
            end else begin
                next_s.sec_in_min = 6'(s.sec_in_min + 6'h01);
            end
            r = bcd_inc(s.cnt.sec, srtc_pkg::ZERO_BCD, srtc_pkg::SEC_MAX);
            c.sec = r[7:0];
            carry = r[8];
            if (carry) begin
                r = bcd_inc(s.cnt.min, srtc_pkg::ZERO_BCD, srtc_pkg::SEC_MAX);
                c.min = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_inc(s.cnt.hour, srtc_pkg::ZERO_BCD, srtc_pkg::HOUR_MAX);
                c.hour = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_inc(s.cnt.day, srtc_pkg::ONE_BCD, srtc_pkg::DAY_MAX);
                c.day = r[7:0];
                r = bcd_inc(s.cnt.date, srtc_pkg::ONE_BCD,
                            month_last(s.cnt.month, s.cnt.year));
                c.date = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_inc(s.cnt.month, srtc_pkg::ONE_BCD, srtc_pkg::MONTH_MAX);
                c.month = r[7:0];
                carry = r[8];
            end
            if (carry) begin
                r = bcd_inc(s.cnt.year, srtc_pkg::ZERO_BCD, srtc_pkg::YEAR_MAX);
                c.year = r[7:0];
            end
            next_s.cnt = c;
            // One cycle copies every field, so no reader sees a half update.
            if (!hold) begin
                next_s.vis.sec   = {s.vis.sec[srtc_pkg::SEC_HALT_BIT], c.sec[6:0]};
                next_s.vis.min   = c.min;
                next_s.vis.hour  = {s.vis.hour[srtc_pkg::HOUR_KICK_BIT], c.hour[6:0]};
                next_s.vis.day   = {s.vis.day[7:srtc_pkg::DAY_FTEST_BIT], c.day[5:0]};
                next_s.vis.date  = c.date;
                next_s.vis.month = c.month;
                next_s.vis.year  = c.year;
            end
        end

        // Commit at the earlier rising strobe; power fail aborts the write.
        if (s.wr_act && !wr_now && bus_ok) begin
            // A blocked write uses up the flag whatever its address.
            if (s.battery_low_flag) begin
                next_s.battery_low_flag = 1'b0;
            end else if (!in_clock_page(s.wr_addr)) begin
                mem_we = 1'b1;
            end else begin
                unique case (s.wr_addr[2:0])
                    srtc_pkg::OFS_CTRL: begin
                        next_s.clock_control = new_ctrl;
                        // Falling write-hold loads the counters and restarts the second.
                        if (s.clock_control[srtc_pkg::CTRL_WRITE_BIT]
                            && !new_ctrl[srtc_pkg::CTRL_WRITE_BIT]) begin
                            // Stop, kick and test flags are not digits; they stay out.
                            next_s.cnt      = s.vis;
                            next_s.cnt.sec  = {1'b0, s.vis.sec[6:0]};
                            next_s.cnt.hour = {1'b0, s.vis.hour[6:0]};
                            next_s.cnt.day  = {2'b00, s.vis.day[5:0]};
                            next_s.pre      = '0;
                            next_s.sub      = '0;
                        end
                    end
                    srtc_pkg::OFS_SEC:   next_s.vis.sec   = s.wr_data;
                    srtc_pkg::OFS_MIN:   next_s.vis.min   = s.wr_data;
                    srtc_pkg::OFS_HOUR:  next_s.vis.hour  = s.wr_data;
                    srtc_pkg::OFS_DAY:   next_s.vis.day   = s.wr_data;
                    srtc_pkg::OFS_DATE:  next_s.vis.date  = s.wr_data;
                    srtc_pkg::OFS_MONTH: next_s.vis.month = s.wr_data;
                    srtc_pkg::OFS_YEAR:  next_s.vis.year  = s.wr_data;
                endcase
            end
        end

        // Read path: the memory read lags the address by one cycle, so does this.
        // Reads are not gated here; power fail only takes the drive enable away.
        next_s.rd_addr = pins.address_lines;
        unique case (s.rd_addr[2:0])
            srtc_pkg::OFS_CTRL:  rd_clk = s.clock_control;
            // With frequency test set the seconds LSB shows a 512 Hz square wave.
            srtc_pkg::OFS_SEC:   rd_clk = {s.vis.sec[7:1],
                                           s.vis.day[srtc_pkg::DAY_FTEST_BIT]
                                           ? s.pre[srtc_pkg::FTEST_TAP] : s.vis.sec[0]};
            srtc_pkg::OFS_MIN:   rd_clk = s.vis.min;
            srtc_pkg::OFS_HOUR:  rd_clk = s.vis.hour;
            srtc_pkg::OFS_DAY:   rd_clk = s.vis.day;
            srtc_pkg::OFS_DATE:  rd_clk = s.vis.date;
            srtc_pkg::OFS_MONTH: rd_clk = s.vis.month;
            srtc_pkg::OFS_YEAR:  rd_clk = s.vis.year;
        endcase
        // Stale data follows an address change until the new access lands.
        next_s.dout = in_clock_page(s.rd_addr) ? rd_clk : mem_rdata;

        // Drive only for a read with both enables low; strobe low releases.
        // Power fail and the init wait both act through bus_ok.
        next_s.doe = bus_ok & ~pins.chip_select_n & ~pins.output_enable_n
                   & pins.write_strobe_n;
    end

    // Counters seed a legal date, so the first carry lands on valid BCD.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s                 <= '0;
            s.clock_control   <= srtc_pkg::CTRL_RESET;
            s.vis.sec         <= srtc_pkg::SEC_RESET;
            s.vis.day         <= srtc_pkg::ONE_BCD;
            s.vis.date        <= srtc_pkg::ONE_BCD;
            s.vis.month       <= srtc_pkg::ONE_BCD;
            s.cnt.day         <= srtc_pkg::ONE_BCD;
            s.cnt.date        <= srtc_pkg::ONE_BCD;
            s.cnt.month       <= srtc_pkg::ONE_BCD;
        end else begin
            s <= next_s;
        end
    end

    assign data_lines_out   = s.dout;
    assign data_lines_oe    = s.doe;
    assign battery_low_flag = s.battery_low_flag;

endmodule
`default_nettype wire

// ==== inc/srtc_pkg.sv ====
// Shared constants and carrier types for the clock-calendar SRAM block.
package srtc_pkg;

    // Memory geometry.
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 2048;

    // Clock registers occupy the top page of the address space.
    localparam logic [7:0] CLK_PAGE = 8'hFF;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_SEC = 3'h1;
    localparam logic [2:0] OFS_MIN = 3'h2;
    localparam logic [2:0] OFS_HOUR = 3'h3;
    localparam logic [2:0] OFS_DAY = 3'h4;
    localparam logic [2:0] OFS_DATE = 3'h5;
    localparam logic [2:0] OFS_MONTH = 3'h6;
    localparam logic [2:0] OFS_YEAR = 3'h7;

    // Control register fields.
    localparam int CTRL_WRITE_BIT = 7;
    localparam int CTRL_READ_BIT = 6;
    localparam int CTRL_SIGN_BIT = 5;
    localparam int CAL_MSB = 4;
    localparam logic [4:0] CAL_ZERO = 5'h00;

    // Flag bits inside the time registers.
    localparam int SEC_HALT_BIT = 7;
    localparam int DAY_FTEST_BIT = 6;
    localparam int HOUR_KICK_BIT = 7;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SEC_RESET = 8'h80;
    localparam logic [7:0] ZERO_BCD = 8'h00;
    localparam logic [7:0] ONE_BCD = 8'h01;

    // BCD limits of the calendar counters.
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DAY_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // Time base and calibration.
    localparam int OSC_HZ = 32768;
    localparam int PRESCALE = 128;
    localparam int SUB_PER_SEC = OSC_HZ / PRESCALE;
    localparam logic [6:0] PRE_LAST = 7'(PRESCALE - 1);
    localparam logic [8:0] SUB_TERM_NOM = 9'(SUB_PER_SEC);
    localparam logic [8:0] SUB_TERM_FAST = 9'(SUB_PER_SEC - 128 / PRESCALE);
    localparam logic [8:0] SUB_TERM_SLOW = 9'(SUB_PER_SEC + 256 / PRESCALE);
    localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3B;
    localparam int FTEST_TAP = 5;
    localparam logic [1:0] INIT_WAIT = 2'h3;

    typedef struct packed {
        logic              chip_select_n;
        logic              output_enable_n;
        logic              write_strobe_n;
        logic [ADDR_W-1:0] address_lines;
        logic [DATA_W-1:0] data_lines;
        logic              power_fail;
        logic              battery_low_sense;
        logic              osc_clk;
    } srtc_pins_s;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } srtc_time_s;

    typedef struct packed {
        logic [1:0]        init_cnt;
        logic              init_done;
        logic              battery_low_flag;
        logic              osc_prev;
        logic              wr_act;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic [ADDR_W-1:0] rd_addr;
        logic [7:0]        clock_control;
        srtc_time_s        vis;
        srtc_time_s        cnt;
        logic [6:0]        pre;
        logic [8:0]        sub;
        logic [5:0]        sec_in_min;
        logic [5:0]        cal_min;
        logic [DATA_W-1:0] dout;
        logic              doe;
    } srtc_state_s;

endpackage

// ==== rtl/srtc_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ns
`default_nettype none
module srtc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/srtc_mem.sv ====
// Byte-wide static storage array with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module srtc_mem (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // Write port
    input  wire logic                       wr_en,
    input  wire logic [srtc_pkg::ADDR_W-1:0] wr_addr,
    input  wire logic [srtc_pkg::DATA_W-1:0] wr_data,
    // Read port
    input  wire logic [srtc_pkg::ADDR_W-1:0] rd_addr,
    output var  logic [srtc_pkg::DATA_W-1:0] rd_data
);

    logic [srtc_pkg::DATA_W-1:0] store [srtc_pkg::MEM_DEPTH];

    // The array itself has no reset, as in a real static RAM.
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= store[rd_addr];
        end
    end

endmodule
`default_nettype wire

// ==== tb/srtc_checker.sv ====
// Bus timing checks for the clock-calendar SRAM top.
`timescale 1ns/1ns
`default_nettype none
module srtc_checker (
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        reset_n,
    // Bus and supply pins
    input wire logic                        chip_select_n,
    input wire logic                        output_enable_n,
    input wire logic                        write_strobe_n,
    input wire logic [srtc_pkg::ADDR_W-1:0] address_lines,
    input wire logic [srtc_pkg::DATA_W-1:0] data_lines_out,
    input wire logic                        data_lines_oe,
    input wire logic                        power_fail,
    input wire logic                        battery_low_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic rd_on;
    assign rd_on = !chip_select_n && !output_enable_n && write_strobe_n && !power_fail;
    sequence s_wr;
        (!chip_select_n && !write_strobe_n)[*3] ##1 write_strobe_n;
    endsequence
    sequence s_rd_held;
        (rd_on && $stable(address_lines))[*6];
    endsequence
    a_oe_rise_cause: assert property ($rose(data_lines_oe) |-> $past(rd_on, 3))
        else $error("data drive began without a read select");
    a_read_drives: assert property (rd_on[*4] |-> data_lines_oe)
        else $error("read select held but data lines not driven");
    a_deselect_float: assert property (chip_select_n[*4] |-> !data_lines_oe)
        else $error("data lines driven while deselected");
    a_oe_fall_cause: assert property ($fell(data_lines_oe) |-> $past(!rd_on, 3))
        else $error("data drive dropped during a read select");
    a_write_release: assert property ((!write_strobe_n)[*4] |-> !data_lines_oe)
        else $error("data lines driven while write strobe low");
    a_write_no_drive: assert property (s_wr |-> !data_lines_oe)
        else $error("data lines driven at end of write");
    a_pfail_float: assert property (power_fail[*4] |-> !data_lines_oe)
        else $error("data lines driven during power fail");
    a_flag_steady: assert property (write_strobe_n[*8] |-> $stable(battery_low_flag))
        else $error("battery flag changed without a write");
    a_data_steady: assert property (s_rd_held |-> $stable(data_lines_out))
        else $error("read data moved under a steady address");
endmodule
`default_nettype wire

// ==== tb/srtc_host.sv ====
// Host model that runs byte reads and writes on the asynchronous bus.
`timescale 1ns/1ns
`default_nettype none
module srtc_host (
    // Clock
    input  wire logic                        clk_sys,
    // Bus pins
    output var  logic                        chip_select_n,
    output var  logic                        output_enable_n,
    output var  logic                        write_strobe_n,
    output var  logic [srtc_pkg::ADDR_W-1:0] address_lines,
    output var  logic [srtc_pkg::DATA_W-1:0] data_lines_in,
    input  wire logic [srtc_pkg::DATA_W-1:0] data_lines_out,
    input  wire logic                        data_lines_oe
);
    initial begin
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
        write_strobe_n = 1'b1;
        address_lines = 11'h000;
        data_lines_in = 8'h00;
    end
    task automatic wr(input logic [srtc_pkg::ADDR_W-1:0] a, input logic [7:0] d,
                      input logic oe_lo = 1'b0);
        @(posedge clk_sys);
        address_lines <= a;
        data_lines_in <= d;
        output_enable_n <= !oe_lo;
        chip_select_n <= 1'b0;
        write_strobe_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chip_select_n <= 1'b1;
        write_strobe_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Released data shows the inverse so a late sample cannot match by luck.
        data_lines_in <= ~d;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [srtc_pkg::ADDR_W-1:0] a, input logic en,
                      output logic [7:0] d, output logic oe);
        @(posedge clk_sys);
        address_lines <= a;
        chip_select_n <= 1'b0;
        output_enable_n <= !en;
        repeat (6) @(posedge clk_sys);
        d = data_lines_out;
        oe = data_lines_oe;
        chip_select_n <= 1'b1;
        output_enable_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== tb/test_srtc_top.sv ====
// Self-checking bench for the clock-calendar SRAM top.
`timescale 1ns/1ns
`default_nettype none
module test_srtc_top;
    logic        clk_sys;
    logic        reset_n;
    logic        chip_select_n;
    logic        output_enable_n;
    logic        write_strobe_n;
    logic [10:0] address_lines;
    logic [7:0]  data_lines_in;
    logic [7:0]  data_lines_out;
    logic        data_lines_oe;
    logic        power_fail;
    logic        battery_low_sense;
    logic        osc_clk;
    logic        battery_low_flag;
    logic [7:0]  rd_d;
    logic        rd_oe;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [10:0] row_a [5] = '{11'h000, 11'h3FF, 11'h400, 11'h7F7, 11'h7F8};
    logic [7:0]  row_d [5] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A, 8'h3F};

    srtc_host srtc_host_inst (.clk_sys(clk_sys), .chip_select_n(chip_select_n),
        .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
        .address_lines(address_lines), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
    srtc_top srtc_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
        .write_strobe_n(write_strobe_n), .address_lines(address_lines),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .power_fail(power_fail),
        .battery_low_sense(battery_low_sense), .osc_clk(osc_clk),
        .battery_low_flag(battery_low_flag));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // The time base runs far above its real rate so one second fits in the run.
    initial begin
        osc_clk = 1'b0;
        forever #40 osc_clk = ~osc_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input string what, input logic [10:0] a, input logic [7:0] exp);
        srtc_host_inst.rd(a, 1'b1, rd_d, rd_oe);
        check(what, rd_d, exp);
        check({what, " drive"}, {7'h00, rd_oe}, 8'h01);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One trimmed second of the sped-up time base dominates the run.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        reset_n = 1'b0;
        power_fail = 1'b0;
        battery_low_sense = 1'b1;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("flag", {7'h00, battery_low_flag}, 8'h01);
        rd_chk("sec reset", 11'h7F9, 8'h80);
        srtc_host_inst.wr(11'h7F8, 8'h25);
        rd_chk("blocked", 11'h7F8, 8'h00);
        check("flag", {7'h00, battery_low_flag}, 8'h00);
        for (int i = 0; i < 5; i++) srtc_host_inst.wr(row_a[i], row_d[i]);
        for (int i = 0; i < 5; i++) rd_chk("row", row_a[i], row_d[i]);
        srtc_host_inst.wr(11'h7F8, 8'h80);
        srtc_host_inst.wr(11'h7FA, 8'h45);
        srtc_host_inst.wr(11'h7FB, 8'h23);
        srtc_host_inst.wr(11'h7F9, 8'h00);
        // Leaving write-hold with a positive trim of 31 shortens the first second.
        srtc_host_inst.wr(11'h7F8, 8'h3F);
        rd_chk("minutes", 11'h7FA, 8'h45);
        rd_chk("hours", 11'h7FB, 8'h23);
        // A trimmed second ends near cycle 65280, a plain one near 65536.
        repeat (65380) @(posedge clk_sys);
        rd_chk("fast sec", 11'h7F9, 8'h01);
        rd_chk("loaded min", 11'h7FA, 8'h45);
        srtc_host_inst.wr(11'h001, 8'h66, 1'b1);
        rd_chk("oe write", 11'h001, 8'h66);
        srtc_host_inst.rd(11'h000, 1'b0, rd_d, rd_oe);
        check("float", {7'h00, rd_oe}, 8'h00);
        power_fail <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srtc_host_inst.rd(11'h000, 1'b1, rd_d, rd_oe);
        check("pfail float", {7'h00, rd_oe}, 8'h00);
        srtc_host_inst.wr(11'h000, 8'h11);
        power_fail <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk("pfail keep", 11'h000, 8'hA5);
        battery_low_sense <= 1'b0;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check("flag clear", {7'h00, battery_low_flag}, 8'h00);
        rd_chk("sec again", 11'h7F9, 8'h80);
        srtc_host_inst.wr(11'h7F8, 8'h15);
        rd_chk("first ok", 11'h7F8, 8'h15);
        end_sim();
    end
endmodule
bind srtc_top srtc_checker srtc_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .address_lines(address_lines),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .power_fail(power_fail), .battery_low_flag(battery_low_flag));
`default_nettype wire
